//--- src/regs_pkg.sv
// Constants and types for the converter/transmitter control and status registers
`default_nettype none
package regs_pkg;
	// ****************
	// Register offsets
	// ****************
	localparam logic [7:0] ADDR_XMIT_CONTROL_THREE = 8'h09;
	localparam logic [7:0] ADDR_CONVERTER_XMIT_STATUS = 8'h0A;
	localparam logic [7:0] ADDR_CONVERTER_XMIT_IRQ_MASK = 8'h0B;
	localparam logic [7:0] ADDR_CONVERTER_XMIT_IRQ_TRIGGER_MODE = 8'h0C;
	localparam logic [7:0] ADDR_RECEIVER_CONTROL_ONE = 8'h0D;

	// ****************
	// Field positions
	// ****************
	localparam int CU_SRC_LSB = 0;
	localparam int VALIDITY_SEL_BIT = 2;
	localparam int BUF_XFER_BIT = 0;
	localparam int SLIP_BIT = 1;
	localparam int READY_BIT = 4;
	localparam int RATIO_BIT = 5;
	localparam int RX_INPUT_LSB = 0;
	localparam int RX_REF_BIT = 3;
	localparam int RX_DISABLE_BIT = 4;

	// ****************
	// Event indices and reset values
	// ****************
	localparam int NUM_EVENTS = 4;
	localparam int EV_BUF_XFER = 0;
	localparam int EV_SLIP = 1;
	localparam int EV_READY = 2;
	localparam int EV_RATIO = 3;
	localparam logic [7:0] RST_XMIT_CONTROL_THREE = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_IRQ_TRIGGER_MODE = 8'h00;
	localparam logic [7:0] RST_RECEIVER_CONTROL_ONE = 8'h00;
	localparam int CU_HOST_BYTES = 10;

	// ****************
	// Types
	// ****************
	typedef enum logic [1:0] {
		TRIG_RISE = 2'b00,
		TRIG_FALL = 2'b01,
		TRIG_LEVEL = 2'b10,
		TRIG_RSVD = 2'b11
	} trig_t;
	typedef enum logic [1:0] {
		CU_NONE = 2'b00,
		CU_HOST = 2'b01,
		CU_RECV = 2'b10,
		CU_MIXED = 2'b11
	} cu_src_t;
endpackage
`default_nettype wire

//--- src/event_if.sv
// Interface between the register bank and one event detector
`timescale 1ns/100ps
`default_nettype none
interface event_if;
	import regs_pkg::*;
	logic cond;
	logic mask;
	logic ack;
	trig_t mode;
	logic flag;
	modport detector (input cond, input mask, input ack, input mode, output flag);
	modport bank (output cond, output mask, output ack, output mode, input flag);
endinterface
`default_nettype wire

//--- src/event_detect.sv
// One status event: edge or level trigger, mask and read acknowledge
`timescale 1ns/100ps
`default_nettype none
module event_detect
	import regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Event channel
	event_if.detector ev
);
	logic prev_ff;
	logic pending_ff;
	logic hit;

	// ****************
	// Trigger selection
	// ****************
	always_comb begin
		unique case (ev.mode)
			TRIG_RISE: hit = ev.cond & ~prev_ff;
			TRIG_FALL: hit = ~ev.cond & prev_ff;
			TRIG_LEVEL: hit = 1'b0;
			TRIG_RSVD: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= ev.cond;
		end
	end

	// Set wins over acknowledge; mask gates the capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_ff <= 1'b0;
		end else if (hit && ev.mask) begin
			pending_ff <= 1'b1;
		end else if (ev.ack || !ev.mask || ev.mode == TRIG_LEVEL) begin
			pending_ff <= 1'b0;
		end
	end

	assign ev.flag = ev.mask & ((ev.mode == TRIG_LEVEL) ? ev.cond : pending_ff);
endmodule
`default_nettype wire

//--- src/cu_user_buffer.sv
// Transmitter user-access buffer for channel status and user data
`timescale 1ns/100ps
`default_nettype none
module cu_user_buffer
	import regs_pkg::*;
#(
	parameter int BYTES = 24,
	parameter int AW = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Source select
	input wire cu_src_t src,
	// Host writes
	input wire logic host_wr,
	input wire logic [AW-1:0] host_idx,
	input wire logic [7:0] host_data,
	// Receiver-access buffer writes
	input wire logic recv_wr,
	input wire logic [AW-1:0] recv_idx,
	input wire logic [7:0] recv_data,
	// Read port
	input wire logic [AW-1:0] rd_idx,
	output logic [7:0] rd_data_ff
);
	localparam logic [AW-1:0] HOST_LIMIT = AW'(CU_HOST_BYTES);
	logic [7:0] mem [BYTES];
	logic host_ok;
	logic recv_ok;

	// ****************
	// Source gating
	// ****************
	always_comb begin
		host_ok = 1'b0;
		recv_ok = 1'b0;
		unique case (src)
			CU_NONE: ;
			CU_HOST: host_ok = host_wr;
			CU_RECV: recv_ok = recv_wr;
			CU_MIXED: begin
				host_ok = host_wr && host_idx < HOST_LIMIT;
				recv_ok = recv_wr && recv_idx >= HOST_LIMIT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (host_ok && int'(host_idx) < BYTES) begin
			mem[host_idx] <= host_data;
		end
		if (recv_ok && int'(recv_idx) < BYTES && !(host_ok && host_idx == recv_idx)) begin
			mem[recv_idx] <= recv_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= 8'h00;
		end else if (int'(rd_idx) < BYTES) begin
			rd_data_ff <= mem[rd_idx];
		end else begin
			rd_data_ff <= 8'h00;
		end
	end
endmodule
`default_nettype wire

//--- src/xmit_src_irq_and_rx_select_regs.sv
// Converter and transmitter status, interrupt and receiver select registers
`timescale 1ns/100ps
`default_nettype none
module xmit_src_irq_and_rx_select_regs
	import regs_pkg::*;
#(
	parameter int CU_BYTES = 24,
	parameter int CU_AW = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Fields held in other control registers
	input wire logic validity_data,
	input wire logic block_start_or_slip_sel,
	input wire logic xmit_transfer_disable,
	// Transmitter and converter events
	input wire logic ua_to_ta_done,
	input wire logic data_slip,
	input wire logic block_start,
	input wire logic in_rate_fast_done,
	input wire logic out_rate_fast_done,
	input wire logic in_rate_above_out,
	// Validity path
	input wire logic rx_validity,
	output logic tx_validity,
	// Interrupt and summary status
	output logic irq_n,
	output logic xmit_summary,
	output logic converter_summary,
	// Transmitter user-access buffer
	input wire logic cu_host_wr,
	input wire logic [CU_AW-1:0] cu_host_idx,
	input wire logic [7:0] cu_host_data,
	input wire logic cu_recv_wr,
	input wire logic [CU_AW-1:0] cu_recv_idx,
	input wire logic [7:0] cu_recv_data,
	input wire logic [CU_AW-1:0] cu_rd_idx,
	output logic [7:0] cu_rd_data,
	// Receiver selection
	input wire logic [3:0] rx_line,
	output logic rx_core_data,
	input wire logic receiver_clock_input,
	input wire logic master_clock_input,
	output logic pll1_reference,
	output logic receiver_copy_en
);
	// ****************
	// Register state
	// ****************
	logic [7:0] xmit_control_three_ff;
	logic [7:0] converter_xmit_irq_mask_ff;
	logic [7:0] converter_xmit_irq_trigger_mode_ff;
	logic [7:0] receiver_control_one_ff;
	logic [7:0] converter_xmit_status;
	logic irq_n_ff;
	logic xmit_summary_ff;
	logic converter_summary_ff;
	logic status_ack;
	logic [NUM_EVENTS-1:0] ev_flag;
	logic [NUM_EVENTS-1:0] ev_cond;
	logic [5:0] raw_evt;
	logic [5:0] evt_meta_ff;
	logic [5:0] evt_sync_ff;
	logic xfer_done_sync;
	logic data_slip_sync;
	logic block_start_sync;
	logic in_fast_sync;
	logic out_fast_sync;
	logic rate_above_sync;

	// Decoded fields
	cu_src_t xmit_cu_source_sel;
	logic validity_source_sel;
	logic [1:0] receiver_input_sel;
	logic receiver_reference_sel;
	logic receiver_transfer_disable;

	// ****************
	// Address decode
	// ****************
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	// ****************
	// Event bit mapping
	// ****************
	// Status and mask bit that belongs to each event
	function automatic int ev_bit(input int e);
		unique case (e)
			EV_BUF_XFER: ev_bit = BUF_XFER_BIT;
			EV_SLIP: ev_bit = SLIP_BIT;
			EV_READY: ev_bit = READY_BIT;
			default: ev_bit = RATIO_BIT;
		endcase
	endfunction

	// ****************
	// Register writes
	// ****************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xmit_control_three_ff <= RST_XMIT_CONTROL_THREE;
		end else if (reg_wr && hit(reg_addr, ADDR_XMIT_CONTROL_THREE)) begin
			xmit_control_three_ff <= {5'h00, reg_wdata[2:0]};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_xmit_irq_mask_ff <= RST_IRQ_MASK;
		end else if (reg_wr && hit(reg_addr, ADDR_CONVERTER_XMIT_IRQ_MASK)) begin
			for (int e = 0; e < NUM_EVENTS; e++) begin
				converter_xmit_irq_mask_ff[ev_bit(e)] <= reg_wdata[ev_bit(e)];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_xmit_irq_trigger_mode_ff <= RST_IRQ_TRIGGER_MODE;
		end else if (reg_wr && hit(reg_addr, ADDR_CONVERTER_XMIT_IRQ_TRIGGER_MODE)) begin
			converter_xmit_irq_trigger_mode_ff <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			receiver_control_one_ff <= RST_RECEIVER_CONTROL_ONE;
		end else if (reg_wr && hit(reg_addr, ADDR_RECEIVER_CONTROL_ONE)) begin
			receiver_control_one_ff <= {3'h0, reg_wdata[4:3], 1'b0, reg_wdata[1:0]};
		end
	end

	// ****************
	// Field extraction
	// ****************
	assign xmit_cu_source_sel = cu_src_t'(xmit_control_three_ff[CU_SRC_LSB +: 2]);
	assign validity_source_sel = xmit_control_three_ff[VALIDITY_SEL_BIT];
	assign receiver_input_sel = receiver_control_one_ff[RX_INPUT_LSB +: 2];
	assign receiver_reference_sel = receiver_control_one_ff[RX_REF_BIT];
	assign receiver_transfer_disable = receiver_control_one_ff[RX_DISABLE_BIT];

	// ****************
	// Validity source
	// ****************
	// Combinational so the received bit passes without delay
	always_comb begin
		if (validity_source_sel) begin
			tx_validity = rx_validity;
		end else begin
			tx_validity = validity_data;
		end
	end

	// ****************
	// Event input synchronisers
	// ****************
	// Events arrive from the transmitter and converter clocks
	assign raw_evt = {in_rate_above_out, out_rate_fast_done, in_rate_fast_done,
		block_start, data_slip, ua_to_ta_done};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_meta_ff <= 6'h00;
			evt_sync_ff <= 6'h00;
		end else begin
			evt_meta_ff <= raw_evt;
			evt_sync_ff <= evt_meta_ff;
		end
	end

	// Only the second stage is read
	assign {rate_above_sync, out_fast_sync, in_fast_sync,
		block_start_sync, data_slip_sync, xfer_done_sync} = evt_sync_ff;

	// ****************
	// Event conditions
	// ****************
	assign ev_cond[EV_BUF_XFER] = xfer_done_sync & ~xmit_transfer_disable;
	assign ev_cond[EV_SLIP] = block_start_or_slip_sel ? block_start_sync : data_slip_sync;
	assign ev_cond[EV_READY] = in_fast_sync & out_fast_sync;
	assign ev_cond[EV_RATIO] = rate_above_sync;

	// Status read acknowledges pending edge events
	assign status_ack = reg_rd && hit(reg_addr, ADDR_CONVERTER_XMIT_STATUS);

	// ****************
	// Event detectors
	// ****************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_ev
			localparam int BITPOS = ev_bit(gi);
			event_if ev_link ();
			assign ev_link.cond = ev_cond[gi];
			assign ev_link.mask = converter_xmit_irq_mask_ff[BITPOS];
			assign ev_link.mode = trig_t'(converter_xmit_irq_trigger_mode_ff[2*gi +: 2]);
			assign ev_link.ack = status_ack;
			assign ev_flag[gi] = ev_link.flag;
			event_detect u_event_detect (
				.clk(clk),
				.rst_n(rst_n),
				.ev(ev_link)
			);
		end
	endgenerate

	// ****************
	// Status register
	// ****************
	always_comb begin
		converter_xmit_status = 8'h00;
		converter_xmit_status[BUF_XFER_BIT] = ev_flag[EV_BUF_XFER];
		converter_xmit_status[SLIP_BIT] = ev_flag[EV_SLIP];
		converter_xmit_status[READY_BIT] = ev_flag[EV_READY];
		converter_xmit_status[RATIO_BIT] = ev_flag[EV_RATIO];
	end

	// ****************
	// Interrupt and summary outputs
	// ****************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xmit_summary_ff <= 1'b0;
		end else begin
			xmit_summary_ff <= ev_flag[EV_BUF_XFER] | ev_flag[EV_SLIP];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_summary_ff <= 1'b0;
		end else begin
			converter_summary_ff <= ev_flag[EV_READY] | ev_flag[EV_RATIO];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_n_ff <= 1'b1;
		end else begin
			irq_n_ff <= ~(|ev_flag);
		end
	end

	assign irq_n = irq_n_ff;
	assign xmit_summary = xmit_summary_ff;
	assign converter_summary = converter_summary_ff;

	// ****************
	// Register read
	// ****************
	// Unmapped offsets read as zero; status has no write path
	always_comb begin
		reg_rdata = 8'h00;
		if (hit(reg_addr, ADDR_XMIT_CONTROL_THREE)) begin
			reg_rdata = xmit_control_three_ff;
		end else if (hit(reg_addr, ADDR_CONVERTER_XMIT_STATUS)) begin
			reg_rdata = converter_xmit_status;
		end else if (hit(reg_addr, ADDR_CONVERTER_XMIT_IRQ_MASK)) begin
			reg_rdata = converter_xmit_irq_mask_ff;
		end else if (hit(reg_addr, ADDR_CONVERTER_XMIT_IRQ_TRIGGER_MODE)) begin
			reg_rdata = converter_xmit_irq_trigger_mode_ff;
		end else if (hit(reg_addr, ADDR_RECEIVER_CONTROL_ONE)) begin
			reg_rdata = receiver_control_one_ff;
		end
	end

	// ****************
	// Transmitter user-access buffer
	// ****************
	// Nothing is stored until the host picks a non-zero source
	cu_user_buffer #(
		.BYTES(CU_BYTES),
		.AW(CU_AW)
	) u_cu_user_buffer (
		.clk(clk),
		.rst_n(rst_n),
		.src(xmit_cu_source_sel),
		.host_wr(cu_host_wr),
		.host_idx(cu_host_idx),
		.host_data(cu_host_data),
		.recv_wr(cu_recv_wr),
		.recv_idx(cu_recv_idx),
		.recv_data(cu_recv_data),
		.rd_idx(cu_rd_idx),
		.rd_data_ff(cu_rd_data)
	);

	// ****************
	// Receiver input and reference selection
	// ****************
	always_comb begin
		unique case (receiver_input_sel)
			2'b00: rx_core_data = rx_line[0];
			2'b01: rx_core_data = rx_line[1];
			2'b10: rx_core_data = rx_line[2];
			2'b11: rx_core_data = rx_line[3];
		endcase
	end

	always_comb begin
		if (receiver_reference_sel) begin
			pll1_reference = master_clock_input;
		end else begin
			pll1_reference = receiver_clock_input;
		end
	end

	// ****************
	// Receiver buffer copy control
	// ****************
	// Host may freeze copies for a stable read
	assign receiver_copy_en = ~receiver_transfer_disable;
endmodule
`default_nettype wire

//--- verification/regs_chk.sv
// Checker for the register bank port behaviour
`timescale 1ns/100ps
`default_nettype none
module regs_chk
	import regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Observed pins
	input wire logic validity_data,
	input wire logic rx_validity,
	input wire logic tx_validity,
	input wire logic irq_n,
	input wire logic xmit_summary,
	input wire logic converter_summary,
	input wire logic [3:0] rx_line,
	input wire logic rx_core_data,
	input wire logic receiver_clock_input,
	input wire logic master_clock_input,
	input wire logic pll1_reference,
	input wire logic receiver_copy_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ****************
	// Sequences
	// ****************
	sequence mask_wr;
		reg_wr && reg_addr == 8'h0B ##1 reg_addr == 8'h0B;
	endsequence
	// ****************
	// Assertions
	// ****************
	AST_VALID_REG:
	assert property (reg_addr == 8'h09 && !reg_rdata[2] |-> tx_validity == validity_data) else $error("validity bit");
	AST_VALID_PASS:
	assert property (reg_addr == 8'h09 && reg_rdata[2] |-> tx_validity == rx_validity) else $error("validity pass");
	AST_RX_MUX:
	assert property (reg_addr == 8'h0D |-> rx_core_data == rx_line[reg_rdata[1:0]]) else $error("input select");
	AST_RX_REF:
	assert property (reg_addr == 8'h0D |-> pll1_reference == (reg_rdata[3] ? master_clock_input : receiver_clock_input))
		else $error("reference select");
	AST_RX_COPY:
	assert property (reg_addr == 8'h0D |-> receiver_copy_en == !reg_rdata[4]) else $error("copy enable");
	AST_STATUS_ZERO:
	assert property (reg_addr == 8'h0A |-> (reg_rdata & 8'hCC) == 8'h00) else $error("status unused bits");
	AST_IRQ_LINK:
	assert property (irq_n == !(xmit_summary || converter_summary)) else $error("interrupt versus summary");
	AST_CONV_SUM:
	assert property (reg_addr == 8'h0A |=> converter_summary == |($past(reg_rdata) & 8'h30)) else $error("converter summary");
	AST_XMIT_SUM:
	assert property (reg_addr == 8'h0A |=> xmit_summary == |($past(reg_rdata) & 8'h03)) else $error("transmitter summary");
	AST_MASK_WR:
	assert property (mask_wr |-> reg_rdata == ($past(reg_wdata) & 8'h33)) else $error("mask write");
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking testbench for the register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import regs_pkg::*;
	logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, validity_data = 0, rx_validity = 0;
	logic block_start_or_slip_sel = 0, xmit_transfer_disable = 0, ua_to_ta_done = 0, data_slip = 0;
	logic block_start = 0, in_rate_fast_done = 0, out_rate_fast_done = 0, in_rate_above_out = 0;
	logic cu_host_wr = 0, cu_recv_wr = 0, receiver_clock_input = 0, master_clock_input = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cu_host_data = 8'h00, cu_recv_data = 8'h00;
	logic [4:0] cu_host_idx = 5'h00, cu_recv_idx = 5'h00, cu_rd_idx = 5'h00;
	logic [3:0] rx_line = 4'h0;
	logic [7:0] reg_rdata, cu_rd_data;
	logic tx_validity, irq_n, xmit_summary, converter_summary, rx_core_data, pll1_reference, receiver_copy_en;
	logic [7:0] cu_exp[24];
	int bad_count = 0, total_checks = 0, cycles = 0;
	xmit_src_irq_and_rx_select_regs u_xmit_src_irq_and_rx_select_regs (.*);
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			complete_run();
		end
	end
	// ****************
	// Shared tasks
	// ****************
	task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_bit(input string name, input logic exp, input logic got);
		check_byte(name, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, input logic ack, input logic [7:0] exp);
		@(negedge clk);
		reg_addr = a;
		reg_rd = ack;
		#1;
		check_byte("reg_rdata", exp, reg_rdata);
		@(negedge clk);
		reg_rd = 1'b0;
	endtask
	task automatic cu_write(input logic [1:0] s, input logic rv, input logic [4:0] idx, input logic [7:0] d);
		@(negedge clk);
		cu_host_wr = ~rv;
		cu_recv_wr = rv;
		cu_host_idx = idx;
		cu_recv_idx = idx;
		cu_host_data = d;
		cu_recv_data = d;
		if (rv ? (s == 2'b10 || (s == 2'b11 && idx >= 10)) : (s == 2'b01 || (s == 2'b11 && idx < 10)))
			cu_exp[idx] = d;
		@(negedge clk);
		cu_host_wr = 1'b0;
		cu_recv_wr = 1'b0;
		cu_rd_idx = idx;
		@(negedge clk);
		check_byte("cu_rd_data", cu_exp[idx], cu_rd_data);
	endtask
	task automatic set_cond(input int e, input logic v);
		case (e)
			0: ua_to_ta_done = v;
			1: data_slip = v;
			2: block_start = v;
			3: begin
				in_rate_fast_done = v;
				out_rate_fast_done = v;
			end
			default: in_rate_above_out = v;
		endcase
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic test_access();
		logic [7:0] a[5] = '{8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h0A};
		logic [7:0] m[5] = '{8'h07, 8'h33, 8'hFF, 8'h1B, 8'h00};
		for (int i = 0; i < 5; i++) begin
			reg_read(a[i], 1'b0, 8'h00);
			reg_write(a[i], 8'hFF);
			reg_read(a[i], 1'b0, m[i]);
			reg_write(a[i], 8'h00);
		end
		reg_write(8'h0E, 8'hFF);
		reg_read(8'h0E, 1'b0, 8'h00);
	endtask
	task automatic test_select();
		for (int i = 0; i < 8; i++) begin
			reg_write(8'h09, {5'h00, i[1], 2'b00});
			reg_write(8'h0D, {3'h0, i[2], i[2], 1'b0, i[1:0]});
			validity_data = i[0];
			rx_validity = ~i[0];
			rx_line = 4'h1 << i[1:0];
			receiver_clock_input = i[0];
			master_clock_input = ~i[0];
			#1;
			check_bit("tx_validity", i[1] ? ~i[0] : i[0], tx_validity);
			check_bit("rx_core_data", 1'b1, rx_core_data);
			check_bit("pll1_reference", i[2] ? ~i[0] : i[0], pll1_reference);
			check_bit("receiver_copy_en", ~i[2], receiver_copy_en);
		end
		reg_write(8'h0D, 8'h00);
	endtask
	task automatic test_buffer();
		reg_write(8'h09, 8'h01);
		cu_write(2'b01, 1'b0, 5'h09, 8'h5A);
		cu_write(2'b01, 1'b0, 5'h0A, 8'hA5);
		for (int i = 0; i < 16; i++) begin
			reg_write(8'h09, {6'h00, i[3:2]});
			cu_write(i[3:2], i[1], i[0] ? 5'h0A : 5'h09, 8'(8'h10 + i));
		end
	endtask
	task automatic test_events();
		logic [7:0] bitv[5] = '{8'h01, 8'h02, 8'h02, 8'h10, 8'h20};
		int pr[5] = '{0, 1, 1, 2, 3};
		logic hi;
		for (int e = 0; e < 5; e++) begin
			block_start_or_slip_sel = (e == 2);
			for (int m = 0; m < 5; m++) begin
				hi = (m == 0 || m == 2);
				reg_write(8'h0B, m == 4 ? 8'h00 : bitv[e]);
				reg_write(8'h0C, 8'({6'h00, m[1:0]} << (2 * pr[e])));
				set_cond(e, 1'b1);
				tick(4);
				reg_read(8'h0A, 1'b0, hi ? bitv[e] : 8'h00);
				check_bit("irq_n", ~hi, irq_n);
				check_bit("xmit_summary", hi && e < 3, xmit_summary);
				check_bit("converter_summary", hi && e > 2, converter_summary);
				set_cond(e, 1'b0);
				tick(4);
				reg_read(8'h0A, 1'b1, m < 2 ? bitv[e] : 8'h00);
				tick(2);
				reg_read(8'h0A, 1'b0, 8'h00);
				check_bit("irq_n", 1'b1, irq_n);
			end
		end
		reg_write(8'h0B, 8'h31);
		reg_write(8'h0C, 8'h00);
		xmit_transfer_disable = 1'b1;
		ua_to_ta_done = 1'b1;
		in_rate_fast_done = 1'b1;
		tick(4);
		reg_read(8'h0A, 1'b0, 8'h00);
		check_bit("irq_n", 1'b1, irq_n);
	endtask
	task automatic test_slip_select();
		reg_write(8'h0B, 8'h02);
		reg_write(8'h0C, 8'h08);
		block_start_or_slip_sel = 1'b0;
		block_start = 1'b1;
		tick(4);
		reg_read(8'h0A, 1'b0, 8'h00);
		block_start_or_slip_sel = 1'b1;
		tick(1);
		reg_read(8'h0A, 1'b0, 8'h02);
		block_start = 1'b0;
		data_slip = 1'b1;
		tick(4);
		reg_read(8'h0A, 1'b0, 8'h00);
		data_slip = 1'b0;
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		check_bit("receiver_copy_en", 1'b1, receiver_copy_en);
		test_access();
		test_select();
		test_buffer();
		test_events();
		test_slip_select();
		complete_run();
	end
endmodule
bind xmit_src_irq_and_rx_select_regs regs_chk u_regs_chk (.*);
`default_nettype wire
